// [include/wps_pkg.sv]
// Package with types and constants of the waveform playback scheduler.
package wps_pkg;

  localparam int NUM_CH = 4;
  localparam int ADDR_W = 16;
  localparam int LEN_W = 16;
  localparam int RATE_W = 4;
  localparam int SMP_W = 16;
  localparam logic [RATE_W-1:0] RATE_RESET = 4'h0;
  localparam logic [NUM_CH-1:0] DIGITAL_PORT_MASK = 4'hF;

  // Command opcodes from the sequencer instruction stream.
  typedef enum logic [2:0] {
    WPS_OP_PLAY_QUEUED = 3'h0,
    WPS_OP_PLAY_IMMEDIATE = 3'h1,
    WPS_OP_PLAY_PART_QUEUED = 3'h2,
    WPS_OP_PLAY_PART_IMMEDIATE = 3'h3,
    WPS_OP_PLAY_DIGITAL_PORT_WAVE = 3'h4,
    WPS_OP_PLAY_SILENCE = 3'h5
  } wps_op_t;

  // One play command as issued by the sequencer.
  typedef struct packed {
    wps_op_t op;
    logic map_valid;
    logic [NUM_CH-1:0] ch_map;
    logic [2:0] num_waves;
    logic [ADDR_W-1:0] base;
    logic [LEN_W-1:0] offset;
    logic [LEN_W-1:0] length;
    logic rate_valid;
    logic [RATE_W-1:0] rate;
  } wps_cmd_t;

  // Playback parameters of one launched waveform.
  typedef struct packed {
    logic [NUM_CH-1:0] ch_en;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0] length;
    logic silence;
    logic four_ch_mode;
    logic [RATE_W-1:0] rate;
  } wps_play_t;

  typedef enum logic [1:0] {
    WPS_IDLE = 2'b01,
    WPS_PLAY = 2'b10
  } wps_state_t;

endpackage

// [verilog/wps_launch_slot.sv]
// Holding slot for one queued play command waiting on the active waveform.
module wps_launch_slot (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire wps_pkg::wps_play_t load_data,
  input wire logic take,
  output logic full,
  output wps_pkg::wps_play_t data
);

  logic next_full;
  wps_pkg::wps_play_t next_data;

  // A load in the same cycle as a take refills the slot.
  always_comb begin
    next_full = full;
    next_data = data;
    if (take) begin
      next_full = 1'b0;
    end
    if (load) begin
      next_full = 1'b1;
      next_data = load_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full <= 1'b0;
      data <= '0;
    end else begin
      full <= next_full;
      data <= next_data;
    end
  end

endmodule

// [verilog/wps_scheduler.sv]
// Waveform playback scheduler: decodes play commands and drives sample playback.
module wps_scheduler #(
  parameter int NUM_CH = wps_pkg::NUM_CH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire wps_pkg::wps_cmd_t cmd,
  input wire logic [wps_pkg::RATE_W-1:0] default_sample_rate,
  input wire logic [wps_pkg::SMP_W-1:0] mem_rdata,
  output logic cmd_ready,
  output logic mem_rd,
  output logic [wps_pkg::ADDR_W-1:0] mem_addr,
  output logic [NUM_CH-1:0] ch_valid,
  output logic [wps_pkg::SMP_W-1:0] sample,
  output logic [wps_pkg::RATE_W-1:0] out_rate,
  output logic four_ch_mode,
  output logic busy,
  output logic play_done
);

  wps_pkg::wps_state_t state, next_state;
  wps_pkg::wps_play_t act, next_act;
  wps_pkg::wps_play_t dec;
  logic [wps_pkg::LEN_W-1:0] remain, next_remain;
  logic next_mem_rd, next_cmd_ready, next_play_done;
  logic [wps_pkg::ADDR_W-1:0] next_mem_addr;
  logic [NUM_CH-1:0] next_ch_valid;
  logic [wps_pkg::RATE_W-1:0] next_out_rate;
  logic next_four, next_busy, emit_valid, emit_silence;
  logic is_imm, take_cmd, slot_full, slot_load, slot_take, last;
  wps_pkg::wps_play_t slot_data;

  // Decode a command into the playback parameters it launches.
  always_comb begin
    dec = '0;
    dec.addr = cmd.base + cmd.offset;
    dec.length = cmd.length;
    dec.rate = cmd.rate_valid ? cmd.rate : default_sample_rate;
    if (cmd.map_valid) begin
      dec.ch_en = cmd.ch_map;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        dec.ch_en[i] = (i < int'(cmd.num_waves));
      end
    end
    case (cmd.op)
      wps_pkg::WPS_OP_PLAY_QUEUED, wps_pkg::WPS_OP_PLAY_IMMEDIATE: begin
        dec.addr = cmd.base;
      end
      wps_pkg::WPS_OP_PLAY_DIGITAL_PORT_WAVE: begin
        dec.addr = cmd.base;
        dec.four_ch_mode = 1'b1;
      end
      wps_pkg::WPS_OP_PLAY_SILENCE: begin
        dec.addr = '0;
        dec.silence = 1'b1;
        dec.ch_en = wps_pkg::DIGITAL_PORT_MASK;
      end
      default: begin
      end
    endcase
    is_imm = (cmd.op == wps_pkg::WPS_OP_PLAY_IMMEDIATE) ||
             (cmd.op == wps_pkg::WPS_OP_PLAY_PART_IMMEDIATE);
  end

  // Every command, immediate ones too, waits for a free slot.
  // An immediate launch therefore never collides with a waiting queued one.
  assign take_cmd = cmd_valid && cmd_ready;
  assign last = (state == wps_pkg::WPS_PLAY) && (remain == 16'h0001);

  // Scheduler state, sample sequencing and output register values.
  always_comb begin
    next_state = state;
    next_act = act;
    next_remain = remain;
    slot_load = 1'b0;
    slot_take = 1'b0;
    emit_valid = 1'b0;
    emit_silence = 1'b0;
    next_mem_addr = mem_addr;
    next_play_done = last;
    if (state == wps_pkg::WPS_PLAY) begin
      emit_valid = 1'b1;
      emit_silence = act.silence;
      next_mem_addr = act.addr;
      next_act.addr = act.addr + 16'h0001;
      next_remain = remain - 16'h0001;
      if (last) begin
        next_state = wps_pkg::WPS_IDLE;
      end
    end
    if ((state == wps_pkg::WPS_IDLE || last) && slot_full) begin
      slot_take = 1'b1;
      next_act = slot_data;
      next_remain = slot_data.length;
      next_state = wps_pkg::WPS_PLAY;
    end
    if (take_cmd && is_imm) begin
      next_act = dec;
      next_remain = dec.length;
      next_state = wps_pkg::WPS_PLAY;
    end else if (take_cmd) begin
      slot_load = 1'b1;
    end
    next_mem_rd = emit_valid && !emit_silence;
    next_ch_valid = emit_valid ? act.ch_en : '0;
    next_out_rate = emit_valid ? act.rate : out_rate;
    next_four = emit_valid ? act.four_ch_mode : four_ch_mode;
    next_busy = (next_state == wps_pkg::WPS_PLAY);
    // Ready follows the slot as it will be after this edge, so a second command cannot overwrite a waiting one.
    next_cmd_ready = !(slot_load || (slot_full && !slot_take));
  end

  wps_launch_slot u_slot (
    .clk(clk),
    .rst_n(rst_n),
    .load(slot_load),
    .load_data(dec),
    .take(slot_take),
    .full(slot_full),
    .data(slot_data)
  );

  // Sample path: silence samples are forced to zero one cycle after the address.
  logic sil_d, next_sil_d;
  logic [wps_pkg::SMP_W-1:0] next_sample;
  always_comb begin
    next_sil_d = emit_silence;
    next_sample = sil_d ? '0 : mem_rdata;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= wps_pkg::WPS_IDLE;
      act <= '0;
      remain <= '0;
      cmd_ready <= 1'b1;
      mem_rd <= 1'b0;
      mem_addr <= '0;
      ch_valid <= '0;
      out_rate <= wps_pkg::RATE_RESET;
      four_ch_mode <= 1'b0;
      busy <= 1'b0;
      play_done <= 1'b0;
      sil_d <= 1'b0;
      sample <= '0;
    end else begin
      state <= next_state;
      act <= next_act;
      remain <= next_remain;
      cmd_ready <= next_cmd_ready;
      mem_rd <= next_mem_rd;
      mem_addr <= next_mem_addr;
      ch_valid <= next_ch_valid;
      out_rate <= next_out_rate;
      four_ch_mode <= next_four;
      busy <= next_busy;
      play_done <= next_play_done;
      sil_d <= next_sil_d;
      sample <= next_sample;
    end
  end

  // Immediate command restarts the length counter on the next edge.
  chk_immediate_restart: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_ready && is_imm && cmd.length != '0
    |=> state == wps_pkg::WPS_PLAY && remain == $past(cmd.length))
    else $error("immediate command did not restart playback");
  // A queued slot launches on the cycle after the last sample.
  chk_queued_nogap: assert property (@(posedge clk) disable iff (!rst_n)
    last && slot_full && !(cmd_valid && cmd_ready && is_imm)
    |=> state == wps_pkg::WPS_PLAY && remain == $past(slot_data.length))
    else $error("queued waveform did not follow without gap");
  // Done pulse rises one cycle after last, in the same cycle as the last sample's address and channels.
  chk_done_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    last |=> play_done)
    else $error("done pulse missing after last sample");
  // Silence never reads waveform memory.
  chk_silence_noread: assert property (@(posedge clk) disable iff (!rst_n)
    state == wps_pkg::WPS_PLAY && act.silence |=> !mem_rd && ch_valid == wps_pkg::DIGITAL_PORT_MASK)
    else $error("silence read memory or missed a channel");
  // Silence samples come out as zero.
  chk_silence_zero: assert property (@(posedge clk) disable iff (!rst_n)
    sil_d |=> sample == '0)
    else $error("silence sample not zero");
  // Partial play starts reading at base plus offset.
  chk_part_offset: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_ready && cmd.op == wps_pkg::WPS_OP_PLAY_PART_IMMEDIATE && cmd.length != '0
    |=> ##1 mem_addr == $past(cmd.base, 2) + $past(cmd.offset, 2))
    else $error("partial play started at wrong address");
  // Rate falls back to the host default.
  chk_default_rate: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_ready && is_imm && !cmd.rate_valid && cmd.length != '0
    |=> ##1 out_rate == $past(default_sample_rate, 2))
    else $error("default rate not applied");
  // Digital-port play is never immediate and sets four-channel mode.
  chk_digital_mode: assert property (@(posedge clk) disable iff (!rst_n)
    slot_take && slot_data.four_ch_mode |=> act.four_ch_mode)
    else $error("digital-port play lost four-channel mode");
  // Auto assignment enables the low channels by count.
  chk_auto_assign: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && !cmd.map_valid && cmd.op != wps_pkg::WPS_OP_PLAY_SILENCE && cmd.num_waves == 3'h1
    |-> dec.ch_en == 4'h1)
    else $error("automatic channel assignment wrong");
  // Explicit map drives all mapped channels together.
  chk_map_together: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd.map_valid && cmd.op != wps_pkg::WPS_OP_PLAY_SILENCE |-> dec.ch_en == cmd.ch_map)
    else $error("explicit mapping not applied");
  // With nothing waiting, playback stops after its last sample and the channels fall idle a cycle later.
  chk_exact_len: assert property (@(posedge clk) disable iff (!rst_n)
    last && !slot_full && !(cmd_valid && cmd_ready && is_imm)
    |=> state == wps_pkg::WPS_IDLE ##1 ch_valid == '0)
    else $error("playback did not stop after length");

endmodule

// [tb/wps_mem_model.sv]
// Behavioural waveform memory standing at the far side of the scheduler.
module wps_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_rd,
  input wire logic [wps_pkg::ADDR_W-1:0] mem_addr,
  output logic [wps_pkg::SMP_W-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] held;

  // Data is the address scrambled by a fixed pattern; it flows through in the address cycle.
  // The scheduler registers it at the next edge, which puts each sample one cycle after its address.
  // Idle cycles show the inverse of the previous cycle's word, so the bus toggles and the last read word returns every second idle cycle.
  always_comb begin
    mem_rdata = mem_rd ? (mem_addr ^ 16'h5A5A) : ~held;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 16'h0000;
    end else begin
      held <= mem_rdata;
    end
  end
endmodule

// [tb/test_wps_scheduler.sv]
// Self-checking testbench of the waveform playback scheduler.
module test_wps_scheduler;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  wps_pkg::wps_cmd_t cmd = '0;
  logic [3:0] default_sample_rate = 4'h3;
  logic [15:0] mem_rdata;
  logic cmd_ready, mem_rd, four_ch_mode, busy, play_done;
  logic [15:0] mem_addr, sample;
  logic [3:0] ch_valid, out_rate;
  int failures = 0;
  int n_tests = 0;

  wps_scheduler uut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .default_sample_rate(default_sample_rate), .mem_rdata(mem_rdata), .cmd_ready(cmd_ready),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .ch_valid(ch_valid), .sample(sample), .out_rate(out_rate),
    .four_ch_mode(four_ch_mode), .busy(busy), .play_done(play_done));
  wps_mem_model mem (.clk(clk), .rst_n(rst_n), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Holds the command until the edge that samples cmd_ready high.
  task automatic issue(input wps_pkg::wps_op_t op, input logic mv, input logic [3:0] map,
    input logic [2:0] nw, input logic [15:0] base, input logic [15:0] off, input logic [15:0] len,
    input logic rv, input logic [3:0] rt);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, mv, map, nw, base, off, len, rv, rt};
    @(posedge clk);
    while (cmd_ready !== 1'b1) @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  // Follows one waveform sample by sample; maxw of zero demands it starts without a gap.
  task automatic watch(input logic [15:0] first, input int len, input logic [3:0] ch, input logic [3:0] rt,
    input logic sil, input logic fcm, input int maxw, input logic last);
    logic [15:0] prev;
    int n;
    n = 0;
    prev = 16'h0000;
    #1;
    while (!(ch_valid != 4'h0 && (sil || mem_addr == first)) && n < maxw) begin
      @(posedge clk);
      #1;
      n++;
    end
    for (int i = 0; i < len; i++) begin
      check(ch_valid, ch, "channels");
      check(mem_rd, !sil, "read strobe");
      if (!sil) check(mem_addr, first + i, "address");
      check(out_rate, rt, "rate");
      check(four_ch_mode, fcm, "four channel mode");
      if (i > 0) check(sample, prev, "sample");
      check(play_done, i == len - 1, "done with last sample");
      if (i < len - 1) check(busy, 1'b1, "busy");
      prev = sil ? 16'h0000 : (first + i) ^ 16'h5A5A;
      @(posedge clk);
      #1;
    end
    check(sample, prev, "last sample");
    if (last) begin
      check(ch_valid, 4'h0, "stop");
      check(play_done, 1'b0, "done pulse ends");
      check(busy, 1'b0, "busy");
    end
  endtask

  task automatic t_immediate();
    // Offset must be ignored by a whole-waveform command.
    issue(wps_pkg::WPS_OP_PLAY_IMMEDIATE, 1'b0, 4'h0, 3'h1, 16'h0020, 16'h0007, 16'h0002, 1'b0, 4'h0);
    watch(16'h0020, 2, 4'h1, 4'h3, 1'b0, 1'b0, 4, 1'b1);
    $display("Test immediate done");
  endtask

  task automatic t_queued();
    issue(wps_pkg::WPS_OP_PLAY_QUEUED, 1'b0, 4'h0, 3'h2, 16'h0010, 16'h0000, 16'h0004, 1'b0, 4'h0);
    #1 check(cmd_ready, 1'b0, "ready while slot full");
    issue(wps_pkg::WPS_OP_PLAY_PART_QUEUED, 1'b1, 4'hA, 3'h2, 16'h0040, 16'h0003, 16'h0003, 1'b1, 4'h7);
    watch(16'h0010, 4, 4'h3, 4'h3, 1'b0, 1'b0, 4, 1'b0);
    watch(16'h0043, 3, 4'hA, 4'h7, 1'b0, 1'b0, 0, 1'b1);
    $display("Test queued done");
  endtask

  task automatic t_abandon();
    issue(wps_pkg::WPS_OP_PLAY_IMMEDIATE, 1'b0, 4'h0, 3'h1, 16'h0100, 16'h0000, 16'h0014, 1'b0, 4'h0);
    repeat (3) @(posedge clk);
    issue(wps_pkg::WPS_OP_PLAY_PART_IMMEDIATE, 1'b0, 4'h0, 3'h1, 16'h0200, 16'h0005, 16'h0003, 1'b1, 4'h2);
    watch(16'h0205, 3, 4'h1, 4'h2, 1'b0, 1'b0, 3, 1'b1);
    $display("Test abandon done");
  endtask

  task automatic t_silence_digital();
    @(posedge clk);
    default_sample_rate <= 4'h5;
    // A short but nonzero silence, sized like a stored waveform.
    issue(wps_pkg::WPS_OP_PLAY_SILENCE, 1'b0, 4'h0, 3'h0, 16'h0000, 16'h0000, 16'h0003, 1'b0, 4'h0);
    issue(wps_pkg::WPS_OP_PLAY_DIGITAL_PORT_WAVE, 1'b0, 4'h0, 3'h4, 16'h0080, 16'h0000, 16'h0002, 1'b0, 4'h0);
    watch(16'h0000, 3, 4'hF, 4'h5, 1'b1, 1'b0, 4, 1'b0);
    watch(16'h0080, 2, 4'hF, 4'h5, 1'b0, 1'b1, 0, 1'b1);
    $display("Test silence and digital port done");
  endtask

  // Cuts a hang short well beyond the few dozen cycles the tests need.
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_immediate();
    t_queued();
    t_abandon();
    t_silence_digital();
    conclude();
  end
endmodule
